// ===== common/dhp_pkg.sv
// Purpose: Shared constants and types of the display host bus port
// Assumes: One 100 MHz clock; all pins sampled synchronously
// Notes:   Strap codes pick the host interface style once after reset
package dhp_pkg;

  // Clock rate, bus width and FIFO depth
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned BUS_W      = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // Bit count of the last serial bit; a frame is 8 rising edges of the serial clock
  localparam logic [2:0] SER_LAST_BIT = 3'h7;

  // Bit positions of the serial pins on the data bus
  localparam int unsigned SER_CLK_BIT  = 0;
  localparam int unsigned SER_DATA_BIT = 1;

  // Strap codes {strap_b, strap_a}
  localparam logic [1:0] STRAP_SERIAL = 2'h0;
  localparam logic [1:0] STRAP_ESTRB  = 2'h1;
  localparam logic [1:0] STRAP_SEPSTR = 2'h2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_BITS = 3'h0;

  // Interface style
  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_ESTROBE,
    MODE_SEPSTROBE
  } dhp_mode_t;

  // One transfer from the host: byte plus its data/command flag
  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } dhp_xfer_t;

  localparam int unsigned XFER_W = $bits(dhp_xfer_t);

endpackage

// ===== design/dhp_port.sv
// Purpose: Device end of the display host bus port, with its write FIFO
// Assumes: Host pins synchronous to clk_i; straps stable at reset release
// Notes:   Writes are dropped while the FIFO is full, shown on busy_o one cycle late; the host must pace
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Write FIFO: plain circular buffer with occupancy counter
module dhp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0]    wp_q, wp_d;     // Write pointer
  logic [AW-1:0]    rp_q, rp_d;     // Read pointer
  logic [AW:0]      cnt_q, cnt_d;   // Occupancy
  logic             push, pop;

  // Honest flags straight from the counter
  // Full compare at counter width; a pointer-wide cast of DEPTH wraps to 0
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];

  // Next pointers and count
  always_comb begin
    push  = in_valid_i && in_ready_o;
    pop   = out_valid_o && out_ready_i;
    wp_d  = push ? wp_q + AW'(1) : wp_q;
    rp_d  = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register pointers; memory written on push
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      if (push) begin
        mem_q[wp_q] <= in_data_i;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Port top: decodes host strobes, shifts serial bits, answers reads
module dhp_port (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [7:0]           host_data_bus_i,
  output logic      [7:0]           host_data_bus_o,
  output logic                      host_data_bus_oe_o,
  input  wire logic                 rd_strobe_i,
  input  wire logic                 wr_strobe_i,
  input  wire logic                 chip_select_n_i,
  input  wire logic                 data_command_select_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 bus_select_strap_a_i,
  input  wire logic                 bus_select_strap_b_i,
  input  wire logic [7:0]           status_i,
  input  wire logic [7:0]           mem_data_i,
  output logic                      mem_rd_o,
  output logic                      init_o,
  output logic                      busy_o,
  output logic                      xfer_valid_o,
  output dhp_pkg::dhp_xfer_t        xfer_o,
  input  wire logic                 xfer_ready_i
);
  dhp_pkg::dhp_mode_t mode_q, mode_d;     // Selected style
  logic               taken_q, taken_d;   // Straps caught
  logic               prv_rd_q, prv_wr_q; // Last strobe levels
  logic               prv_sck_q;          // Last serial clock
  logic [7:0]         sh_q, sh_d;         // Serial shifter
  logic [2:0]         bits_q, bits_d;     // Serial bit count
  logic [7:0]         pipe_q, pipe_d;     // Read pipeline byte
  logic [7:0]         dout_d;
  logic               oe_d, mrd_d, init_d, busy_d;
  logic               push_q, push_d;     // One-cycle FIFO write
  dhp_pkg::dhp_xfer_t pdat_q, pdat_d;
  logic               fifo_rdy, fifo_vld;
  dhp_pkg::dhp_xfer_t fifo_dat;
  logic               sel, e_fall, rd_rise, wr_rise, sck_rise;
  logic               wr_done, rd_done, serial_data_in;
  logic [7:0]         ser_byte;

  //////////////////////////////////////////////////////////////////////////
  // Next state of the whole port
  always_comb begin
    // Host reset blocks traffic while init runs
    sel      = !chip_select_n_i && reset_n_i;
    e_fall   = prv_rd_q && !rd_strobe_i;
    rd_rise  = !prv_rd_q && rd_strobe_i;
    wr_rise  = !prv_wr_q && wr_strobe_i;
    serial_data_in     = host_data_bus_i[dhp_pkg::SER_DATA_BIT];
    sck_rise = !prv_sck_q
               && host_data_bus_i[dhp_pkg::SER_CLK_BIT];
    ser_byte = {sh_q[6:0], serial_data_in};
    mode_d   = mode_q;
    taken_d  = 1'b1;
    sh_d     = sh_q;
    bits_d   = bits_q;
    pipe_d   = pipe_q;
    push_d   = 1'b0;
    pdat_d   = pdat_q;
    oe_d     = 1'b0;
    wr_done  = 1'b0;
    rd_done  = 1'b0;
    init_d   = !reset_n_i;
    busy_d   = !fifo_rdy;
    // Straps sampled once after release, never again
    if (!taken_q) begin
      case ({bus_select_strap_b_i, bus_select_strap_a_i})
        dhp_pkg::STRAP_ESTRB:  mode_d = dhp_pkg::MODE_ESTROBE;
        dhp_pkg::STRAP_SEPSTR: mode_d = dhp_pkg::MODE_SEPSTROBE;
        default:               mode_d = dhp_pkg::MODE_SERIAL;
      endcase
    end
    case (mode_q)
      dhp_pkg::MODE_ESTROBE: begin
        // Enable high drives on read; falling edge latches
        oe_d    = sel && rd_strobe_i && wr_strobe_i;
        wr_done = sel && e_fall && !wr_strobe_i;
        rd_done = sel && e_fall && wr_strobe_i;
      end
      dhp_pkg::MODE_SEPSTROBE: begin
        // Low strobe opens the access, rising edge closes it
        oe_d    = sel && !rd_strobe_i && wr_strobe_i;
        wr_done = sel && wr_rise && rd_strobe_i;
        rd_done = sel && rd_rise;
      end
      dhp_pkg::MODE_SERIAL: begin
        // Counter restarts whenever select is dropped
        if (!sel) begin
          bits_d = dhp_pkg::RST_BITS;
        end else if (sck_rise) begin
          sh_d   = ser_byte;
          bits_d = bits_q + 3'h1;
          if (bits_q == dhp_pkg::SER_LAST_BIT) begin
            push_d         = 1'b1;
            pdat_d.value   = ser_byte;
            pdat_d.is_data = data_command_select_i;
          end
        end
      end
      default: begin
        oe_d = 1'b0;
      end
    endcase
    // Parallel write: byte straight off the bus
    if (wr_done) begin
      push_d         = 1'b1;
      pdat_d.value   = host_data_bus_i;
      pdat_d.is_data = data_command_select_i;
    end
    // Data reads return the previous fetch, hence the dummy read
    mrd_d = rd_done && data_command_select_i;
    if (mrd_d) begin
      pipe_d = mem_data_i;
    end
    dout_d = data_command_select_i ? pipe_q : status_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // Register the port state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q             <= dhp_pkg::MODE_SERIAL;
      taken_q            <= 1'b0;
      prv_rd_q           <= 1'b0;
      prv_wr_q           <= 1'b0;
      prv_sck_q          <= 1'b0;
      sh_q               <= dhp_pkg::RST_BYTE;
      bits_q             <= dhp_pkg::RST_BITS;
      pipe_q             <= dhp_pkg::RST_BYTE;
      push_q             <= 1'b0;
      pdat_q             <= '0;
      host_data_bus_o    <= dhp_pkg::RST_BYTE;
      host_data_bus_oe_o <= 1'b0;
      mem_rd_o           <= 1'b0;
      init_o             <= 1'b1;
      busy_o             <= 1'b0;
    end else if (ce_i) begin
      mode_q             <= mode_d;
      taken_q            <= taken_d;
      prv_rd_q           <= rd_strobe_i;
      prv_wr_q           <= wr_strobe_i;
      prv_sck_q          <= host_data_bus_i[dhp_pkg::SER_CLK_BIT];
      sh_q               <= sh_d;
      bits_q             <= bits_d;
      pipe_q             <= pipe_d;
      push_q             <= push_d;
      pdat_q             <= pdat_d;
      host_data_bus_o    <= dout_d;
      host_data_bus_oe_o <= oe_d;
      mem_rd_o           <= mrd_d;
      init_o             <= init_d;
      busy_o             <= busy_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFO between host writes and the controller core
  dhp_fifo #(
    .WIDTH (dhp_pkg::XFER_W),
    .DEPTH (dhp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_q),
    .in_data_i   (pdat_q),
    .in_ready_o  (fifo_rdy),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_dat),
    .out_ready_i (xfer_ready_i)
  );

  // Output stream straight from the FIFO storage
  assign xfer_valid_o = fifo_vld;
  assign xfer_o       = fifo_dat;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_e_write;
    mode_q == dhp_pkg::MODE_ESTROBE && sel && e_fall && !wr_strobe_i;
  endsequence
  sequence seq_sep_write;
    mode_q == dhp_pkg::MODE_SEPSTROBE && sel && wr_rise && rd_strobe_i;
  endsequence

  chk_e_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i and seq_e_write) |=> push_q
      && pdat_q.value == $past(host_data_bus_i))
    else $error("E-strobe write not latched");
  chk_sep_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i and seq_sep_write) |=> push_q
      && pdat_q.is_data == $past(data_command_select_i))
    else $error("Write strobe rise not latched");
  chk_cs_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && chip_select_n_i |=> !host_data_bus_oe_o && !mem_rd_o)
    else $error("Bus driven while deselected");
  chk_sep_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_q == dhp_pkg::MODE_SEPSTROBE && sel && !rd_strobe_i
      && wr_strobe_i |=> host_data_bus_oe_o)
    else $error("Read strobe low did not drive bus");
  chk_e_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_q == dhp_pkg::MODE_ESTROBE && sel && rd_strobe_i
      && wr_strobe_i |=> host_data_bus_oe_o)
    else $error("Enable read did not drive bus");
  chk_init_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !reset_n_i |=> init_o && !push_q)
    else $error("Init not shown during host reset");
  chk_mode_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    taken_q |=> $stable(mode_q))
    else $error("Interface style changed at run time");
  chk_read_pipe: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mrd_d |=> mem_rd_o && pipe_q == $past(mem_data_i))
    else $error("Read pipeline byte not loaded");
  chk_ser_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_q == dhp_pkg::MODE_SERIAL && sel && sck_rise
      && bits_q == dhp_pkg::SER_LAST_BIT |=> push_q
      && pdat_q.value[0] == $past(serial_data_in))
    else $error("Serial byte not completed");
endmodule

// ===== verification/dhp_host_model.sv
// Purpose: Host processor model driving the display port pins
// Assumes: Pins change just after a rising edge, held to the latch edge
// Notes:   A released bus shows the inverse of its last value; serial style keeps only bit 1
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module dhp_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_bus_i,
  input  wire logic       dev_oe_i,
  output logic      [7:0] bus_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic            cs_n_o,
  output logic            dc_o
);
  logic [1:0] mode;    // Strap code in use
  logic [7:0] got;     // Last byte read back
  logic       got_oe;  // Device drive seen mid read

  // Quiet pins between transfers
  initial begin
    mode   = dhp_pkg::STRAP_SEPSTR;
    bus_o  = 8'h00;
    rd_o   = 1'b1;
    wr_o   = 1'b1;
    cs_n_o = 1'b1;
    dc_o   = 1'b0;
  end

  // Release: serial clock stands still low, no stale bus value
  task idle();
    cs_n_o <= 1'b1;
    rd_o   <= (mode != dhp_pkg::STRAP_ESTRB);
    wr_o   <= 1'b1;
    bus_o  <= ~bus_o & ((mode == dhp_pkg::STRAP_SERIAL) ? 8'h02 : 8'hFF);
  endtask

  // One parallel access; rw high reads
  task automatic par(input logic rw, cs_n, dc, input logic [7:0] b);
    logic e;
    e = (mode == dhp_pkg::STRAP_ESTRB);
    @(posedge clk_i);
    cs_n_o <= cs_n;
    dc_o   <= dc;
    wr_o   <= rw;           // Direction or write strobe
    rd_o   <= e | ~rw;      // Enable high or read strobe low
    if (!rw) bus_o <= b;
    @(posedge clk_i);
    @(negedge clk_i);
    got    = dev_bus_i;
    got_oe = dev_oe_i;
    @(posedge clk_i);
    rd_o   <= ~e;           // Enable falls or read strobe rises
    wr_o   <= e ? rw : 1'b1; // Write strobe rises
    @(posedge clk_i);
    idle();
  endtask

  // Serial frame of n bits, first bit is the MSB
  task automatic ser(input logic dc, cs_n, input logic [7:0] b,
                     input int n);
    int i;
    @(posedge clk_i);
    cs_n_o <= cs_n;
    dc_o   <= dc;
    for (i = 7; i > 7 - n; i--) begin
      @(posedge clk_i);
      bus_o <= {6'h00, b[i], 1'b0}; // Data on bit 1, clock bit 0
      @(posedge clk_i);
      bus_o[0] <= 1'b1;
    end
    @(posedge clk_i);
    idle();
  endtask
endmodule

// ===== verification/display_host_bus_port_tb.sv
// Purpose: Self-checking bench of the display host bus port
// Assumes: Host model on the pins, random stalling consumer
// Notes:   Each strap style is run after its own reset
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module display_host_bus_port_tb;
  logic clk_i, rst_i, reset_n, sa, sb, ready, hold, oe, d;
  logic mem_rd, init, busy, xv, rd, wr, cs_n, dc;
  logic [7:0] hbus, dbus, dev_bus, status, mem, pipe;
  logic [1:0] m;
  dhp_pkg::dhp_xfer_t xfer;         // Word leaving the FIFO
  logic [8:0] expq[$];              // Words still expected
  logic [31:0] seed = 32'hADFBE5F5; // Fixed seed
  int failures, comparisons, reads, pulses, i;

  // Bus level: device wins while it drives
  assign dbus = oe ? dev_bus : hbus;

  dhp_port dhp_port_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .host_data_bus_i(dbus), .host_data_bus_o(dev_bus),
    .host_data_bus_oe_o(oe), .rd_strobe_i(rd), .wr_strobe_i(wr),
    .chip_select_n_i(cs_n), .data_command_select_i(dc),
    .reset_n_i(reset_n), .bus_select_strap_a_i(sa),
    .bus_select_strap_b_i(sb), .status_i(status), .mem_data_i(mem),
    .mem_rd_o(mem_rd), .init_o(init), .busy_o(busy), .xfer_valid_o(xv),
    .xfer_o(xfer), .xfer_ready_i(ready));
  dhp_host_model dhp_host_model_i (.clk_i(clk_i), .dev_bus_i(dbus),
    .dev_oe_i(oe), .bus_o(hbus), .rd_o(rd), .wr_o(wr), .cs_n_o(cs_n),
    .dc_o(dc));

  // Xorshift source
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task cmp_word(input logic [8:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_flag(input logic got, exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask

  task print_verdict();
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Consumer stalls at random; each word checked in order
  always @(posedge clk_i) begin
    ready <= ~hold & rnd() > 32'h7FFFFFFF;
    if (mem_rd) pulses++;
    if (xv & ready & ~rst_i) begin
      if (expq.size() == 0) cmp_flag(1'b1, 1'b0);
      else cmp_word(xfer, expq.pop_front());
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, far above the few hundred cycles needed
  initial begin
    #500000;
    failures++;
    print_verdict();
  end

  task do_reset(input logic [1:0] s);
    rst_i <= 1'b1;
    {sb, sa} <= s;
    dhp_host_model_i.mode = s;
    status <= 8'(rnd());
    @(posedge clk_i);
    dhp_host_model_i.idle(); // Pins rest at the new style's idle levels
    repeat (4) @(posedge clk_i);
    cmp_flag(init, 1'b1);
    cmp_flag(oe | xv | busy, 1'b0);
    rst_i <= 1'b0;
    pipe = 8'h00;
    repeat (2) @(posedge clk_i);
  endtask

  // Write one byte; only counted when select is low
  task wr_byte(input logic dc_v, cs_v, input logic [7:0] b);
    if (m == dhp_pkg::STRAP_SERIAL) dhp_host_model_i.ser(dc_v, cs_v, b, 8);
    else dhp_host_model_i.par(1'b0, cs_v, dc_v, b);
    if (!cs_v) expq.push_back({dc_v, b});
  endtask

  // Data reads return the previous fetch, status reads status
  task rd_byte(input logic dc_v);
    dhp_host_model_i.par(1'b1, 1'b0, dc_v, 8'h00);
    cmp_flag(dhp_host_model_i.got_oe, 1'b1);
    cmp_word({1'b0, dhp_host_model_i.got},
             {1'b0, (dc_v ? pipe : status)});
    if (dc_v) pipe = mem;
    if (dc_v) reads++;
    repeat (2) @(posedge clk_i);
    mem <= 8'(rnd());
  endtask

  task drain();
    for (i = 0; i < 400 && expq.size() > 0; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    cmp_flag(expq.size() == 0, 1'b1);
  endtask

  initial begin
    {rst_i, reset_n, sa, sb, hold, ready} = 6'h30;
    {status, mem} = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? dhp_pkg::STRAP_SEPSTR :
          (k == 1) ? dhp_pkg::STRAP_ESTRB : dhp_pkg::STRAP_SERIAL;
      do_reset(m);
      {reads, pulses} = 0;
      repeat (6) begin
        d = rnd() > 32'h7FFFFFFF;
        wr_byte(d, 1'b0, 8'(rnd()));
      end
      wr_byte(1'b1, 1'b1, 8'(rnd()));
      if (m != dhp_pkg::STRAP_SERIAL) begin
        for (i = 0; i < 3; i++) rd_byte(1'b1);
        rd_byte(1'b0);
        dhp_host_model_i.par(1'b1, 1'b1, 1'b1, 8'h00);
        cmp_flag(dhp_host_model_i.got_oe, 1'b0);
      end else begin
        dhp_host_model_i.ser(1'b1, 1'b0, 8'(rnd()), 4); // Cut frame
        wr_byte(1'b0, 1'b0, 8'hC3);
      end
      drain();
      cmp_word(9'(pulses), 9'(reads));
      if (k == 0) begin
        hold <= 1'b1;
        repeat (3) @(posedge clk_i);
        repeat (16) wr_byte(1'b1, 1'b0, 8'(rnd()));
        // Push lands one edge late, the FIFO count one more and busy is registered one more
        repeat (3) @(posedge clk_i);
        cmp_flag(busy, 1'b1);
        dhp_host_model_i.par(1'b0, 1'b0, 1'b1, 8'hA5); // Dropped when full
        hold <= 1'b0;
        drain();
        cmp_flag(busy, 1'b0);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_flag(init, 1'b1);
        dhp_host_model_i.par(1'b0, 1'b0, 1'b1, 8'h5A);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmp_flag(init | xv, 1'b0);
        drain();
      end
    end
    print_verdict();
  end
endmodule
